// >>> cifd_decode.sv
// Instruction field decoder with return and rotate execution
`timescale 1ns/100ps
module cifd_decode #(
  parameter int DEPTH = cifd_pkg::STACK_DEPTH
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Fetched word and its file operand
  input  wire logic                  instr_valid,
  input  wire logic [13:0]           instr,
  input  wire logic [7:0]            file_data,
  input  wire logic                  irq_take,
  // Decoded fields
  output cifd_pkg::cifd_fields_t     fields,
  output logic                       fields_valid,
  // Core state
  output logic [14:0]                pc,
  output logic [7:0]                 acc,
  output logic                       carry,
  output logic                       global_irq_enable,
  output logic                       fetch_flush,
  output cifd_pkg::cifd_fwr_t        file_wr
);

  // ------------------------------------------------------------
  // Instruction classification
  // ------------------------------------------------------------
  logic        take;
  logic        irq_go;
  logic        is_ret;
  logic        is_iret;
  logic        is_lret;
  logic        is_rot;
  logic        is_call;
  logic        is_absolute_jump;
  logic        any_ret;
  logic [14:0] stack_top;
  logic [13:0] word_q;

  // A word arriving during the idle slot is the stale fetch and is dropped
  assign take    = instr_valid && !fetch_flush;
  assign irq_go  = take && irq_take && global_irq_enable;
  assign is_ret  = take && !irq_go && instr == cifd_pkg::OPC_RETURN;
  assign is_iret = take && !irq_go && instr == cifd_pkg::OPC_IRQ_RETURN;
  assign is_lret = take && !irq_go && instr[13:8] == cifd_pkg::OPC_LIT_RETURN;
  assign is_rot  = take && !irq_go && instr[13:8] == cifd_pkg::OPC_ROTATE;
  assign is_call = take && !irq_go && instr[13:11] == cifd_pkg::OPC_SUB_JUMP;
  assign is_absolute_jump = take && !irq_go && instr[13:11] == cifd_pkg::OPC_ABS_JUMP;
  assign any_ret = is_ret || is_iret || is_lret;

  // ------------------------------------------------------------
  // Return stack
  // ------------------------------------------------------------
  cifd_ret_stack #(
    .DEPTH (DEPTH),
    .AW    (15)
  ) u_stack (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .push      (is_call || irq_go),
    .pop       (any_ret),
    .push_addr (pc + 15'h0001),
    .top       (stack_top)
  );

  // ------------------------------------------------------------
  // Field split, every format decoded side by side
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fields       <= '0;
      fields_valid <= 1'b0;
      word_q       <= '0;
    end else begin
      fields_valid <= take && !irq_go;
      if (take) begin
        word_q            <= instr;
        fields.op_byte    <= instr[13:8];
        fields.byte_dest  <= instr[7];
        fields.file_addr  <= instr[6:0];
        fields.op_bit     <= instr[13:10];
        fields.bit_pos    <= instr[9:7];
        fields.op_lit     <= instr[13:8];
        fields.lit8       <= instr[7:0];
        fields.op_jump    <= instr[13:11];
        fields.lit11      <= instr[10:0];
        fields.op_lit7    <= instr[13:7];
        fields.lit7       <= instr[6:0];
        fields.op_bank    <= instr[13:5];
        fields.lit5       <= instr[4:0];
        fields.op_rel     <= instr[13:9];
        fields.lit9       <= instr[8:0];
        fields.op_off     <= instr[13:7];
        fields.off_ptr    <= instr[6];
        fields.lit6       <= instr[5:0];
        fields.op_inc     <= instr[13:3];
        fields.inc_ptr    <= instr[2];
        fields.inc_mode   <= instr[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pc <= cifd_pkg::PC_RESET;
    end else if (irq_go) begin
      pc <= cifd_pkg::IRQ_VECTOR;
    end else if (any_ret) begin
      pc <= stack_top;
    end else if (is_call || is_absolute_jump) begin
      pc <= {pc[14:11], instr[10:0]};
    end else if (take) begin
      pc <= pc + 15'h0001;
    end
  end

  // ------------------------------------------------------------
  // Idle slot after a return or interrupt entry
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fetch_flush <= 1'b0;
    end else begin
      fetch_flush <= any_ret || irq_go;
    end
  end

  // ------------------------------------------------------------
  // Global interrupt enable
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      global_irq_enable <= 1'b0;
    end else if (is_iret) begin
      global_irq_enable <= 1'b1;
    end else if (irq_go) begin
      global_irq_enable <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Accumulator, carry and file write-back
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc <= cifd_pkg::W_RESET;
    end else if (is_lret) begin
      acc <= instr[7:0];
    end else if (is_rot && !instr[7]) begin
      acc <= {file_data[6:0], carry};
    end
  end

  // Returns leave carry alone; only the rotate touches it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      carry <= 1'b0;
    end else if (is_rot) begin
      carry <= file_data[7];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= is_rot && instr[7];
      file_wr.addr <= instr[6:0];
      file_wr.data <= {file_data[6:0], carry};
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_byte_dest_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> fields.byte_dest == word_q[7] && fields.file_addr == word_q[6:0])
    else $error("byte format fields wrong");

  a_bit_pos_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take ##1 fields_valid |-> fields.bit_pos == $past(instr[9:7]) && fields.op_bit == $past(instr[13:10]))
    else $error("bit format fields wrong");

  a_lit8_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> {fields.op_lit, fields.lit8} == word_q)
    else $error("literal format fields wrong");

  a_jump_target: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (is_absolute_jump || is_call) |=> pc[10:0] == $past(instr[10:0]) && pc[14:11] == $past(pc[14:11]))
    else $error("jump target not loaded");

  a_lit7_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> {fields.op_lit7, fields.lit7} == word_q)
    else $error("short literal fields wrong");

  a_bank_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> {fields.op_bank, fields.lit5} == word_q)
    else $error("bank load fields wrong");

  a_rel_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> {fields.op_rel, fields.lit9} == word_q)
    else $error("relative jump fields wrong");

  a_ptr_off_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> {fields.op_off, fields.off_ptr, fields.lit6} == word_q)
    else $error("pointer offset fields wrong");

  a_ptr_inc_split: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fields_valid |-> {fields.op_inc, fields.inc_ptr, fields.inc_mode} == word_q)
    else $error("pointer increment fields wrong");

  a_irq_return_pop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_iret |=> global_irq_enable && pc == $past(stack_top) && $stable(carry) && fetch_flush)
    else $error("interrupt return wrong");

  a_sub_return_pop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_ret |=> pc == $past(stack_top) && $stable(carry) && $stable(acc) ##1 !fetch_flush)
    else $error("subroutine return wrong");

  a_lit_return_acc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_lret |=> acc == $past(instr[7:0]) && pc == $past(stack_top) && $stable(carry))
    else $error("literal return wrong");

  a_rotate_carry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_rot |=> carry == $past(file_data[7]) && !fetch_flush
      && (file_wr.we ? file_wr.data == {$past(file_data[6:0]), $past(carry)}
                     : acc == {$past(file_data[6:0]), $past(carry)}))
    else $error("rotate through carry wrong");

  a_flush_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    any_ret ##1 instr_valid |=> !fields_valid && $stable(pc))
    else $error("stale word not discarded");

endmodule

// >>> cifd_pkg.sv
// Constants, field layouts and carrier types for the instruction field decoder
// Function
// - Byte-oriented file operations take a 7-bit file address and a destination bit, 0 to accumulator, 1 to the file.
// - Bit-oriented file operations take a 3-bit bit position in bits 9..7, a 7-bit file address in 6..0, opcode 13..10.
// - General literal and control operations take opcode from bits 13..8 and an 8-bit immediate from 7..0.
// - Subroutine and absolute jumps take opcode from bits 13..11 and an 11-bit target from 10..0.
// - The short literal format takes opcode from bits 13..7 and a 7-bit immediate from 6..0.
// - Bank select load takes opcode from bits 13..5 and a 5-bit immediate from 4..0.
// - The relative jump takes opcode from bits 13..9 and a 9-bit immediate from 8..0.
// - Pointer offset operations take the pointer select in bit 6 and a 6-bit immediate in 5..0, opcode 13..7.
// - Pointer increment operations take the pointer select in bit 2 and a 2-bit mode in 1..0, opcode 13..3.
// - Interrupt return pops the stack into the program counter, sets the global enable, takes two cycles.
// - Subroutine return pops the stack into the program counter in two cycles and touches no flags.
// - Literal return loads the accumulator with the 8-bit literal and reloads the counter from the stack top.
// - Rotate left through carry shifts the file value through carry to accumulator or file in one cycle.
package cifd_pkg;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int          INSTR_W     = 14;
  localparam int          PC_W        = 15;
  localparam int          STACK_DEPTH = 16;
  localparam logic [14:0] PC_RESET    = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR  = 15'h0004;
  localparam logic [7:0]  W_RESET     = 8'h00;

  // ------------------------------------------------------------
  // Opcode encodings (plain defaults)
  // ------------------------------------------------------------
  localparam logic [13:0] OPC_RETURN     = 14'h0008;
  localparam logic [13:0] OPC_IRQ_RETURN = 14'h0009;
  localparam logic [5:0]  OPC_LIT_RETURN = 6'h34;
  localparam logic [5:0]  OPC_ROTATE     = 6'h0D;
  localparam logic [2:0]  OPC_SUB_JUMP   = 3'h4;
  localparam logic [2:0]  OPC_ABS_JUMP   = 3'h5;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  op_byte;
    logic        byte_dest;
    logic [6:0]  file_addr;
    logic [3:0]  op_bit;
    logic [2:0]  bit_pos;
    logic [5:0]  op_lit;
    logic [7:0]  lit8;
    logic [2:0]  op_jump;
    logic [10:0] lit11;
    logic [6:0]  op_lit7;
    logic [6:0]  lit7;
    logic [8:0]  op_bank;
    logic [4:0]  lit5;
    logic [4:0]  op_rel;
    logic [8:0]  lit9;
    logic [6:0]  op_off;
    logic        off_ptr;
    logic [5:0]  lit6;
    logic [10:0] op_inc;
    logic        inc_ptr;
    logic [1:0]  inc_mode;
  } cifd_fields_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } cifd_fwr_t;

endpackage

// >>> cifd_ret_stack.sv
// Circular return address stack for the instruction field decoder
`timescale 1ns/100ps
module cifd_ret_stack #(
  parameter int DEPTH = 16,
  parameter int AW    = 15
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  // Stack operations
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] push_addr,
  output logic      [AW-1:0] top
);

  localparam int PW = $clog2(DEPTH);

  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] ptr;

  // Overflow wraps and overwrites the oldest entry, no error is raised
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr <= '0;
    end else if (push) begin
      ptr <= ptr + PW'(1);
    end else if (pop) begin
      ptr <= ptr - PW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[ptr] <= push_addr;
    end
  end

  assign top = mem[ptr - PW'(1)];

endmodule

// >>> tb_cpu_instruction_field_decode.sv
// Self-checking testbench for the instruction field decoder
`timescale 1ns/100ps
module tb_cpu_instruction_field_decode;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                   sys_clk;
  logic                   rst_b;
  logic                   instr_valid;
  logic [13:0]            instr;
  logic [7:0]             file_data;
  logic                   irq_take;
  cifd_pkg::cifd_fields_t fields;
  logic                   fields_valid;
  logic [14:0]            pc;
  logic [7:0]             acc;
  logic                   carry;
  logic                   global_irq_enable;
  logic                   fetch_flush;
  cifd_pkg::cifd_fwr_t    file_wr;
  int                     n_mismatch;
  int                     comparisons;

  cifd_decode dut (
    .sys_clk           (sys_clk),
    .rst_b             (rst_b),
    .instr_valid       (instr_valid),
    .instr             (instr),
    .file_data         (file_data),
    .irq_take          (irq_take),
    .fields            (fields),
    .fields_valid      (fields_valid),
    .pc                (pc),
    .acc               (acc),
    .carry             (carry),
    .global_irq_enable (global_irq_enable),
    .fetch_flush       (fetch_flush),
    .file_wr           (file_wr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Presents one word; keep leaves it on the port for the following cycle
  task automatic step(input logic [13:0] w, input logic [7:0] fd, input logic irq, input logic keep);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr       <= w;
    file_data   <= fd;
    irq_take    <= irq;
    @(posedge sys_clk);
    if (!keep) begin
      instr_valid <= 1'b0;
      irq_take    <= 1'b0;
    end
    #1;
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_reset;
    chk("pc", 16'h0000, {1'b0, pc});
    chk("acc", 16'h0000, {8'h00, acc});
    chk("irq_en", 16'h0000, {15'h0, global_irq_enable});
    chk("fvalid", 16'h0000, {15'h0, fields_valid});
  endtask

  task automatic sc_fields;
    logic [13:0] w;
    logic [13:0] tbl [2];
    tbl[0] = 14'h1ABC;
    tbl[1] = 14'h3F3F;
    for (int i = 0; i < 2; i++) begin
      w = tbl[i];
      step(w, 8'h00, 1'b0, 1'b0);
      chk("fvalid", 16'h0001, {15'h0, fields_valid});
      chk("pc", 16'(i + 1), {1'b0, pc});
      chk("op_byte", {10'h0, w[13:8]}, {10'h0, fields.op_byte});
      chk("dest", {15'h0, w[7]}, {15'h0, fields.byte_dest});
      chk("faddr", {9'h0, w[6:0]}, {9'h0, fields.file_addr});
      chk("op_bit", {12'h0, w[13:10]}, {12'h0, fields.op_bit});
      chk("bitpos", {13'h0, w[9:7]}, {13'h0, fields.bit_pos});
      chk("op_lit", {10'h0, w[13:8]}, {10'h0, fields.op_lit});
      chk("lit8", {8'h0, w[7:0]}, {8'h0, fields.lit8});
      chk("op_jump", {13'h0, w[13:11]}, {13'h0, fields.op_jump});
      chk("lit11", {5'h0, w[10:0]}, {5'h0, fields.lit11});
      chk("op_lit7", {9'h0, w[13:7]}, {9'h0, fields.op_lit7});
      chk("lit7", {9'h0, w[6:0]}, {9'h0, fields.lit7});
      chk("op_bank", {7'h0, w[13:5]}, {7'h0, fields.op_bank});
      chk("lit5", {11'h0, w[4:0]}, {11'h0, fields.lit5});
      chk("op_rel", {11'h0, w[13:9]}, {11'h0, fields.op_rel});
      chk("lit9", {7'h0, w[8:0]}, {7'h0, fields.lit9});
      chk("op_off", {9'h0, w[13:7]}, {9'h0, fields.op_off});
      chk("optr", {15'h0, w[6]}, {15'h0, fields.off_ptr});
      chk("lit6", {10'h0, w[5:0]}, {10'h0, fields.lit6});
      chk("op_inc", {5'h0, w[13:3]}, {5'h0, fields.op_inc});
      chk("iptr", {15'h0, w[2]}, {15'h0, fields.inc_ptr});
      chk("imode", {14'h0, w[1:0]}, {14'h0, fields.inc_mode});
    end
  endtask

  // Return with the fetched word left on the port during the idle slot
  task automatic sc_call_return;
    step({3'h4, 11'h123}, 8'h00, 1'b0, 1'b0);
    chk("pc", 16'h0123, {1'b0, pc});
    step(14'h0008, 8'h00, 1'b0, 1'b1);
    chk("pc", 16'h0003, {1'b0, pc});
    chk("flush", 16'h0001, {15'h0, fetch_flush});
    chk("irq_en", 16'h0000, {15'h0, global_irq_enable});
    step(14'h1ABC, 8'h00, 1'b0, 1'b0);
    chk("pc", 16'h0004, {1'b0, pc});
    chk("flush", 16'h0000, {15'h0, fetch_flush});
  endtask

  task automatic sc_absolute_jump_litret;
    step({3'h5, 11'h050}, 8'h00, 1'b0, 1'b0);
    chk("pc", 16'h0050, {1'b0, pc});
    step({3'h4, 11'h200}, 8'h00, 1'b0, 1'b0);
    chk("pc", 16'h0200, {1'b0, pc});
    step({6'h34, 8'hA5}, 8'h00, 1'b0, 1'b0);
    chk("acc", 16'h00A5, {8'h00, acc});
    chk("pc", 16'h0051, {1'b0, pc});
    chk("carry", 16'h0000, {15'h0, carry});
    chk("flush", 16'h0001, {15'h0, fetch_flush});
  endtask

  task automatic sc_irq;
    step(14'h1ABC, 8'h00, 1'b1, 1'b0);
    chk("pc", 16'h0052, {1'b0, pc});
    chk("fvalid", 16'h0001, {15'h0, fields_valid});
    step({3'h4, 11'h300}, 8'h00, 1'b0, 1'b0);
    step(14'h0009, 8'h00, 1'b0, 1'b0);
    chk("pc", 16'h0053, {1'b0, pc});
    chk("irq_en", 16'h0001, {15'h0, global_irq_enable});
    chk("carry", 16'h0000, {15'h0, carry});
    step(14'h1ABC, 8'h00, 1'b1, 1'b0);
    chk("pc", 16'h0004, {1'b0, pc});
    chk("irq_en", 16'h0000, {15'h0, global_irq_enable});
    chk("fvalid", 16'h0000, {15'h0, fields_valid});
    chk("flush", 16'h0001, {15'h0, fetch_flush});
    step(14'h0009, 8'h00, 1'b0, 1'b0);
    chk("pc", 16'h0054, {1'b0, pc});
    chk("irq_en", 16'h0001, {15'h0, global_irq_enable});
  endtask

  task automatic sc_rotate;
    step({6'h0D, 1'b1, 7'h25}, 8'hE6, 1'b0, 1'b0);
    chk("we", 16'h0001, {15'h0, file_wr.we});
    chk("waddr", 16'h0025, {9'h0, file_wr.addr});
    chk("wdata", 16'h00CC, {8'h00, file_wr.data});
    chk("carry", 16'h0001, {15'h0, carry});
    chk("acc", 16'h00A5, {8'h00, acc});
    chk("pc", 16'h0055, {1'b0, pc});
    step({6'h0D, 1'b0, 7'h7F}, 8'h81, 1'b0, 1'b0);
    chk("acc", 16'h0003, {8'h00, acc});
    chk("carry", 16'h0001, {15'h0, carry});
    chk("we", 16'h0000, {15'h0, file_wr.we});
    chk("irq_en", 16'h0001, {15'h0, global_irq_enable});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    n_mismatch  = 0;
    comparisons = 0;
    rst_b       = 1'b0;
    instr_valid = 1'b0;
    instr       = 14'h0000;
    file_data   = 8'h00;
    irq_take    = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    sc_reset();
    sc_fields();
    sc_call_return();
    sc_absolute_jump_litret();
    sc_irq();
    sc_rotate();
    end_sim();
  end

endmodule
